// *** verif/spp_prog_model.sv ***
// External programmer model driving the four-wire programming port
`timescale 1ns/100ps
`default_nettype none
module spp_prog_model (
    input  wire logic clock,
    input  wire logic resp,
    output logic      pinClk,
    output logic      pinStrobe,
    output logic      pinHv,
    output logic      pinDin,
    output logic      pinFifth
);
    // Link clock stands low outside frames and execute pulses
    initial begin
        pinClk = 1'b0;
        pinStrobe = 1'b0;
        pinHv = 1'b0;
        pinDin = 1'b0;
        pinFifth = 1'b1;
    end

    task automatic enter();
        pinHv <= 1'b1;
        pinStrobe <= 1'b1;
        repeat (8) @(posedge clock);
        pinHv <= 1'b0;
    endtask

    // 160 ns link period; data held four system clocks either side of the edge
    task automatic frame(input logic [31:0] cmd, output logic [31:0] rsp);
        pinStrobe <= 1'b1;
        for (int i = 31; i >= 0; i--) begin
            @(posedge clock);
            pinDin <= cmd[i];
            pinClk <= 1'b0;
            repeat (4) @(posedge clock);
            rsp[i] = resp;
            pinClk <= 1'b1;
            repeat (3) @(posedge clock);
        end
        @(posedge clock);
        pinClk <= 1'b0;
        // Released data line must not keep showing the last bit
        pinDin <= ~pinDin;
    endtask

    task automatic exec(output logic sawLow, output int n);
        pinStrobe <= 1'b0;
        sawLow = 1'b0;
        for (int p = 0; p < 2; p++) begin
            repeat (4) @(posedge clock);
            pinClk <= 1'b1;
            repeat (6) @(posedge clock);
            if (p == 0) sawLow = (resp === 1'b0);
            pinClk <= 1'b0;
        end
        n = 0;
        while (resp !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
        end
    endtask
endmodule // spp_prog_model
`default_nettype wire

// *** verif/tb_serial_eeprom_programming_port.sv ***
// Testbench for the serial programming port
`timescale 1ns/100ps
`default_nettype none
module tb_serial_eeprom_programming_port;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        pwrOk = 1'b0;
    logic        pready, pslverr, pin2, progMode, sawLow, e;
    logic        pinClk, pinStrobe, pinHv, pinDin, pinFifth;
    logic [31:0] prdata, r, rsp;
    int          error_cnt = 0;
    int          checked = 0;
    int          n;
    // All-ones marks a response that is not compared
    logic [31:0] cmds [9] = '{32'h2000_10A5, 32'h1000_103C, 32'h2100_1000, 32'h1100_1000, 32'h2007_C004,
                              32'h2007_C00C, 32'h2007_C008, 32'h2107_C000, 32'h0000_0000};
    logic [31:0] exps [9] = '{32'hFFFF_FFFF, 32'h0000_10A5, 32'h0000_103C, 32'h0000_10A5, 32'h0000_103C,
                              32'h0007_C004, 32'h0007_C00C, 32'hFFFF_FFFF, 32'h0007_C00C};

    always #10 clock = ~clock;

    spp_prog_port dut_u (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .port_pin_1(pinClk), .port_pin_3(pinStrobe), .port_pin_3_hv(pinHv), .port_pin_4(pinDin),
        .pwrOk(pwrOk), .port_pin_2(pin2), .progMode(progMode)
    );

    spp_prog_model prog_u (
        .clock(clock), .resp(pin2), .pinClk(pinClk), .pinStrobe(pinStrobe), .pinHv(pinHv), .pinDin(pinDin),
        .pinFifth(pinFifth)
    );

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            error_cnt++;
            end_sim();
        end
    endtask

    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        pwrOk <= 1'b1;
        apb(1'b0, spp_pkg::STATUS_OFF, 32'h0, r, e);
        chk("status reset", r, 32'h0);
        chk("status error", {31'h0, e}, 32'h0);
        apb(1'b0, 32'h0000_000C, 32'h0, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        // Shorter write time than the reset value still makes an early handshake visible
        apb(1'b1, spp_pkg::CTRL_OFF, 32'h0000_0040, r, e);
        apb(1'b0, spp_pkg::CTRL_OFF, 32'h0, r, e);
        chk("write time reg", r, 32'h0000_0040);
        $display("Test registers done");
        prog_u.enter();
        repeat (4) @(posedge clock);
        chk("mode entry", {31'h0, progMode}, 32'h1);
        chk("fifth pin", {31'h0, pinFifth}, 32'h1);
        for (int i = 0; i < 9; i++) begin
            prog_u.frame(cmds[i], rsp);
            if (exps[i] !== 32'hFFFF_FFFF) chk("response", rsp, exps[i]);
            prog_u.exec(sawLow, n);
            if (i < 8) chk("busy low", {31'h0, sawLow}, 32'h1);
            chk("handshake", {31'h0, n < 2000}, 32'h1);
            if (n >= 2000) end_sim();
            if (i < 6 && !cmds[i][24]) begin
                chk("write time", {31'h0, n > 40}, 32'h1);
                apb(1'b0, spp_pkg::STATUS_OFF, 32'h0, r, e);
                chk("write done", {31'h0, r[spp_pkg::ST_DONE_BIT]}, 32'h1);
                apb(1'b1, spp_pkg::STATUS_OFF, 32'h1 << spp_pkg::ST_DONE_BIT, r, e);
                apb(1'b0, spp_pkg::STATUS_OFF, 32'h0, r, e);
                chk("done cleared", {31'h0, r[spp_pkg::ST_DONE_BIT]}, 32'h0);
            end
            if (i == 2) begin
                apb(1'b0, spp_pkg::LASTCMD_OFF, 32'h0, r, e);
                chk("last command", r, cmds[2]);
            end
        end
        $display("Test commands done");
        apb(1'b0, spp_pkg::STATUS_OFF, 32'h0, r, e);
        chk("brownout enable", {31'h0, r[spp_pkg::ST_BO_BIT]}, 32'h1);
        chk("mode kept", {31'h0, progMode}, 32'h1);
        pwrOk <= 1'b0;
        n = 0;
        while (progMode !== 1'b0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        chk("power loss", {31'h0, progMode}, 32'h0);
        apb(1'b0, spp_pkg::STATUS_OFF, 32'h0, r, e);
        chk("status mode", {31'h0, r[spp_pkg::ST_MODE_BIT]}, 32'h0);
        $display("Test power loss done");
        end_sim();
    end
endmodule // tb_serial_eeprom_programming_port
`default_nettype wire

// *** verilog/spp_mem.sv ***
// Byte memory with one write port and an asynchronous read port
`timescale 1ns/100ps
`default_nettype none
module spp_mem #(
    parameter int AW = 11
) (
    input  wire logic          clock,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [0:(1<<AW)-1];

    // Nonvolatile contents: no reset on purpose
    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];
endmodule // spp_mem
`default_nettype wire

// *** verilog/spp_pkg.sv ***
// Package with constants and types for the serial programming port
package spp_pkg;
    localparam int          CMD_W       = 32;
    localparam int          ADDR_W      = 11;
    localparam int          CLK_MHZ     = 50;
    localparam int          WR_TIME_US  = 20;
    localparam int          WR_CYCLES   = WR_TIME_US * CLK_MHZ;
    localparam logic [5:0]  BITS_WORD   = 6'h20;
    localparam logic [31:0] STATUS_OFF  = 32'h0000_0000;
    localparam logic [31:0] CTRL_OFF    = 32'h0000_0004;
    localparam logic [31:0] LASTCMD_OFF = 32'h0000_0008;
    localparam int          ST_MODE_BIT = 0;
    localparam int          ST_DONE_BIT = 1;
    localparam int          ST_BUSY_BIT = 2;
    localparam int          ST_BO_BIT   = 3;
    localparam int          INIT_BO_BIT = 2;
    localparam int          INIT_WP_BIT = 3;
    localparam logic [10:0] INIT_ADDR   = 11'h7C0;
    localparam logic [15:0] CTRL_RST    = 16'(WR_CYCLES);

    typedef enum {ST_OFF, ST_WAIT, ST_SHIFT, ST_EXEC, ST_WRITE} spp_state_t;

    typedef struct packed {
        logic hv;
        logic load;
        logic clk;
        logic din;
        logic pwr;
    } spp_pins_t;

    typedef struct packed {
        logic [1:0]  zeroHi;
        logic        selData;
        logic        selCode;
        logic [2:0]  zeroMid;
        logic        rd;
        logic [4:0]  zeroLo;
        logic [10:0] addr;
        logic [7:0]  data;
    } spp_cmd_t;
endpackage

// *** verilog/spp_prog_port.sv ***
// Four-wire serial programming port with APB status and control
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RQ1: Programmer enters programming mode by raising strobe pin to super voltage.
// RQ2: Programmer holds strobe at 5V while clocking in each 32-bit command.
// RQ3: Command words travel MSB first, bit 31 on the first clock.
// RQ4: While a command shifts in, previous response shifts out bit for bit.
// RQ5: Programmer samples response bits about 500ns after rising clock; the model samples 160 ns after, just before its next rising clock.
// RQ6: First response word after mode entry has no defined content.
// RQ7: Programmer drops strobe to 0V and gives two clocks to execute.
// RQ8: Response pin goes low by the second rising edge of execute.
// RQ9: Finished write sets the write-done flag and releases response pin high.
// RQ10: Programmer waits for response pin high before next command phase.
// RQ11: Read loads addressed byte into response low byte after second edge.
// RQ12: Response bits 18 to 8 echo the command address.
// RQ13: Programmer drives unused command bits as zero.
// RQ14: Command bit 29 selects data memory and initialization registers.
// RQ15: Command bit 28 selects code memory.
// RQ16: Command bit 24 is one for read, zero for write.
// RQ17: Bits 7 to 0 carry write data; response returns written or read byte.
// RQ18: Eleven-bit address maps to the normal processor memory locations.
// RQ19: Programming mode ends only on power loss.
// RQ20: Fifth port pin is left open or driven high during programming.
// RQ21: Brown-out enable set only here; clear only without global write protect.
// RQ22: Serial input captured on rising clock; output changes after that edge.
module spp_prog_port #(
    parameter int WR_CYC = spp_pkg::WR_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        port_pin_1,
    input  wire logic        port_pin_3,
    input  wire logic        port_pin_3_hv,
    input  wire logic        port_pin_4,
    input  wire logic        pwrOk,
    output logic             port_pin_2,
    output logic             progMode
);
    localparam logic [15:0] WR_RST = 16'(WR_CYC);

    spp_pkg::spp_pins_t  syncPins;
    spp_pkg::spp_state_t state_reg;
    spp_pkg::spp_state_t state_next;
    spp_pkg::spp_cmd_t   cmd_reg;
    spp_pkg::spp_cmd_t   cmd_next;
    logic [31:0]         resp_reg;
    logic [31:0]         resp_next;
    logic [5:0]          bitCnt_reg;
    logic [5:0]          bitCnt_next;
    logic                edgeCnt_reg;
    logic                edgeCnt_next;
    logic [15:0]         wrCnt_reg;
    logic [15:0]         wrCnt_next;
    logic                shiftOut_next;
    logic                clkPrev_reg;
    logic                writeDone_reg;
    logic                boEn_reg;
    logic [15:0]         wrCycles_reg;
    logic [31:0]         lastCmd_reg;
    logic [31:0]         statusWord;
    logic [31:0]         rdMux;

    // Pins come from the programmer's domain
    spp_sync #(
        .W(5)
    ) uSync (
        .clock  (clock),
        .sys_rst(sys_rst),
        .d      ({port_pin_3_hv, port_pin_3, port_pin_1, port_pin_4, pwrOk}),
        .q      (syncPins)
    );

    // Edge found on the synchronised pin: link clock must run well below clock
    wire clkRise  = syncPins.clk & ~clkPrev_reg;
    wire inShift  = (state_reg == spp_pkg::ST_SHIFT);
    wire inExec   = (state_reg == spp_pkg::ST_EXEC);
    wire inWrite  = (state_reg == spp_pkg::ST_WRITE);
    wire shiftClk = inShift & syncPins.load & clkRise;
    wire execFire = inExec & clkRise & edgeCnt_reg;
    wire execLow  = inExec & clkRise & ~edgeCnt_reg;

    // Data space wins if a command selects both spaces
    wire dataSel  = cmd_reg.selData;                            // RQ14
    wire codeSel  = cmd_reg.selCode & ~cmd_reg.selData;         // RQ15
    wire isWrite  = ~cmd_reg.rd & (dataSel | codeSel);          // RQ16
    wire initHit  = dataSel & (cmd_reg.addr == spp_pkg::INIT_ADDR);
    wire dataWe   = execFire & isWrite & dataSel;
    wire codeWe   = execFire & isWrite & codeSel;

    logic [7:0] dataRd;
    logic [7:0] codeRd;
    logic [7:0] dataWdata;

    // Same addresses the core uses in normal operation
    spp_mem #(
        .AW(spp_pkg::ADDR_W)
    ) uDataMem (
        .clock(clock),
        .we   (dataWe),
        .addr (cmd_reg.addr),                                    // RQ18
        .wdata(dataWdata),
        .rdata(dataRd)
    );

    spp_mem #(
        .AW(spp_pkg::ADDR_W)
    ) uCodeMem (
        .clock(clock),
        .we   (codeWe),
        .addr (cmd_reg.addr),                                    // RQ18
        .wdata(cmd_reg.data),
        .rdata(codeRd)
    );

    // Protected brown-out enable survives a clear attempt
    wire boKeep = dataRd[spp_pkg::INIT_BO_BIT] & dataRd[spp_pkg::INIT_WP_BIT];

    always_comb begin
        dataWdata = cmd_reg.data;
        if (initHit) begin
            dataWdata[spp_pkg::INIT_BO_BIT] = cmd_reg.data[spp_pkg::INIT_BO_BIT] | boKeep; // RQ21
        end
    end

    wire [7:0]  memRd    = dataSel ? dataRd : (codeSel ? codeRd : 8'h00);
    wire [7:0]  opData   = cmd_reg.rd ? memRd : cmd_reg.data;           // RQ11 RQ17
    wire [31:0] respWord = {13'h0000, cmd_reg.addr, opData};            // RQ12
    // Zero write time behaves as one cycle
    wire        wrLast   = (wrCnt_reg + 16'h0001) >= wrCycles_reg;

    always_comb begin
        state_next    = state_reg;
        cmd_next      = cmd_reg;
        resp_next     = resp_reg;
        bitCnt_next   = bitCnt_reg;
        edgeCnt_next  = edgeCnt_reg;
        wrCnt_next    = wrCnt_reg;
        shiftOut_next = port_pin_2;
        case (state_reg)
            spp_pkg::ST_OFF: begin
                shiftOut_next = 1'b1;
                if (syncPins.hv) begin
                    // Response left as is: its content is undefined here
                    state_next = spp_pkg::ST_WAIT;               // RQ6
                end
            end
            spp_pkg::ST_WAIT: begin
                if (syncPins.load & ~syncPins.hv) begin
                    state_next    = spp_pkg::ST_SHIFT;
                    bitCnt_next   = 6'h00;
                    shiftOut_next = resp_reg[31];                // RQ4
                end
            end
            spp_pkg::ST_SHIFT: begin
                if (~syncPins.load) begin
                    state_next   = spp_pkg::ST_EXEC;
                    edgeCnt_next = 1'b0;
                end else if (clkRise) begin
                    cmd_next      = {cmd_reg[30:0], syncPins.din}; // RQ3 RQ22
                    resp_next     = {resp_reg[30:0], 1'b0};        // RQ4
                    shiftOut_next = resp_reg[30];                  // RQ22
                    if (bitCnt_reg != spp_pkg::BITS_WORD) begin
                        bitCnt_next = bitCnt_reg + 6'h01;
                    end
                end
            end
            spp_pkg::ST_EXEC: begin
                if (execLow) begin
                    shiftOut_next = 1'b0;                        // RQ8
                    edgeCnt_next  = 1'b1;
                end else if (execFire) begin
                    resp_next = respWord;                        // RQ11 RQ12
                    if (isWrite) begin
                        state_next = spp_pkg::ST_WRITE;
                        wrCnt_next = 16'h0000;
                    end else begin
                        state_next    = spp_pkg::ST_WAIT;
                        shiftOut_next = 1'b1;
                    end
                end
            end
            spp_pkg::ST_WRITE: begin
                wrCnt_next = wrCnt_reg + 16'h0001;
                if (wrLast) begin
                    state_next    = spp_pkg::ST_WAIT;
                    shiftOut_next = 1'b1;                        // RQ9
                end
            end
            default: begin
                state_next = spp_pkg::ST_OFF;
            end
        endcase
        // Only a supply loss leaves the mode
        if (~syncPins.pwr) begin
            state_next    = spp_pkg::ST_OFF;                     // RQ19
            shiftOut_next = 1'b1;
        end
    end

    wire setDone = inWrite & wrLast & syncPins.pwr;              // RQ9

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg   <= spp_pkg::ST_OFF;
            cmd_reg     <= '0;
            resp_reg    <= 32'h0000_0000;
            bitCnt_reg  <= 6'h00;
            edgeCnt_reg <= 1'b0;
            wrCnt_reg   <= 16'h0000;
            port_pin_2  <= 1'b1;
            progMode    <= 1'b0;
            clkPrev_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cmd_reg     <= cmd_next;
            resp_reg    <= resp_next;
            bitCnt_reg  <= bitCnt_next;
            edgeCnt_reg <= edgeCnt_next;
            wrCnt_reg   <= wrCnt_next;
            port_pin_2  <= shiftOut_next;
            progMode    <= (state_next != spp_pkg::ST_OFF);      // RQ19
            clkPrev_reg <= syncPins.clk;
        end
    end

    // APB slave: one wait state so read data comes from a flop
    wire apbAcc  = psel & penable;
    wire apbDone = apbAcc & pready;
    wire selSt   = (paddr == spp_pkg::STATUS_OFF);
    wire selCtl  = (paddr == spp_pkg::CTRL_OFF);
    wire selLast = (paddr == spp_pkg::LASTCMD_OFF);
    wire mapped  = selSt | selCtl | selLast;
    wire clrDone = apbDone & pwrite & selSt & pwdata[spp_pkg::ST_DONE_BIT];
    wire wrCtl   = apbDone & pwrite & selCtl;

    always_comb begin
        statusWord                       = 32'h0000_0000;
        statusWord[spp_pkg::ST_MODE_BIT] = progMode;
        statusWord[spp_pkg::ST_DONE_BIT] = writeDone_reg;
        statusWord[spp_pkg::ST_BUSY_BIT] = inWrite;
        statusWord[spp_pkg::ST_BO_BIT]   = boEn_reg;
    end

    assign rdMux = selSt   ? statusWord :
                   selCtl  ? {16'h0000, wrCycles_reg} :
                   selLast ? lastCmd_reg : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbAcc & ~pready;
            prdata  <= (apbAcc & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
            pslverr <= apbAcc & ~pready & ~mapped;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            writeDone_reg <= 1'b0;
            wrCycles_reg  <= WR_RST;
            lastCmd_reg   <= 32'h0000_0000;
            boEn_reg      <= 1'b0;
        end else begin
            // A completion in the clearing cycle is kept
            writeDone_reg <= setDone | (writeDone_reg & ~clrDone);   // RQ9
            if (wrCtl) begin
                wrCycles_reg <= pwdata[15:0];
            end
            if (execFire) begin
                lastCmd_reg <= cmd_reg;
            end
            if (dataWe & initHit) begin
                boEn_reg <= dataWdata[spp_pkg::INIT_BO_BIT];         // RQ21
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    chk_msb_first: assert property (shiftClk ##1 syncPins.pwr |-> cmd_reg[0] == $past(syncPins.din)) // RQ3
        else $error("command bit not shifted in at lsb");
    chk_resp_shift: assert property (shiftClk && syncPins.pwr |=> port_pin_2 == $past(resp_reg[30])) // RQ4
        else $error("response bit not advanced after clock");
    chk_first_bit: assert property ((state_reg == spp_pkg::ST_WAIT && state_next == spp_pkg::ST_SHIFT)
                                    |=> port_pin_2 == $past(resp_reg[31])) // RQ22
        else $error("response msb not presented before first clock");
    chk_exec_low: assert property (execLow && syncPins.pwr |=> !port_pin_2) // RQ8
        else $error("response pin not low during execute");
    chk_write_done: assert property (setDone |=> writeDone_reg && port_pin_2 && state_reg == spp_pkg::ST_WAIT) // RQ9
        else $error("write completion not flagged");
    chk_busy_low: assert property (inWrite && !wrLast && syncPins.pwr |=> !port_pin_2) // RQ8
        else $error("response pin released before write end");
    chk_read_data: assert property (execFire && cmd_reg.rd && syncPins.pwr
                                    |=> resp_reg[7:0] == $past(memRd) && resp_reg[31:19] == 13'h0000) // RQ11
        else $error("read byte not loaded into response");
    chk_addr_echo: assert property (execFire && syncPins.pwr |=> resp_reg[18:8] == $past(cmd_reg.addr)) // RQ12
        else $error("address not echoed in response");
    chk_power_exit: assert property (!syncPins.pwr |=> !progMode && state_reg == spp_pkg::ST_OFF) // RQ19
        else $error("mode held after power loss");
    chk_bo_guard: assert property (dataWe && initHit && boKeep |=> boEn_reg) // RQ21
        else $error("protected brown-out enable was cleared");
    chk_apb_wait: assert property (apbAcc && !pready |=> pready)
        else $error("apb answer missing after one wait state");

    // A clock pulse outside a frame must leave the command untouched
    chk_cmd_hold: assert property (!shiftClk |=> $stable(cmd_reg)) // RQ22
        else $error("command register changed without a link clock");
    chk_idle_high: assert property (state_reg == spp_pkg::ST_OFF |=> port_pin_2) // RQ19
        else $error("response pin not high outside programming mode");
    chk_mode_flag: assert property (progMode == (state_reg != spp_pkg::ST_OFF)) // RQ19
        else $error("mode flag disagrees with the port state");
    chk_read_release: assert property (execFire && !isWrite && syncPins.pwr
                                       |=> port_pin_2 && state_reg == spp_pkg::ST_WAIT) // RQ16
        else $error("read did not release the handshake");
    chk_write_busy: assert property (execFire && isWrite && syncPins.pwr |=> inWrite && !port_pin_2) // RQ9
        else $error("write did not hold the handshake low");
    chk_done_clear: assert property (clrDone && !setDone |=> !writeDone_reg) // RQ9
        else $error("write-done flag not cleared by software");
    chk_last_cmd: assert property (execFire |=> lastCmd_reg == $past(cmd_reg))
        else $error("executed command not recorded");
    // Refused accesses must not leak register contents
    chk_apb_err: assert property (apbAcc && !pready && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_apb_single: assert property (pready |=> !pready)
        else $error("apb answer held longer than one cycle");

    cov_read_cmd: cover property (execFire && cmd_reg.rd ##1 port_pin_2);
    cov_write_cmd: cover property (setDone);
    cov_mode_entry: cover property (state_reg == spp_pkg::ST_OFF ##1 state_reg == spp_pkg::ST_WAIT);
    cov_done_clear: cover property (clrDone && writeDone_reg);
    cov_bo_protect: cover property (dataWe && initHit && boKeep);
endmodule // spp_prog_port
`default_nettype wire

// *** verilog/spp_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module spp_sync #(
    parameter int W = 5
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // spp_sync
`default_nettype wire
